// >>> verilog/embi_pkg.sv
// Package: constants and types for the external memory bus interface
package embi_pkg;
  localparam int          EMBI_ADDR_W  = 24;   // External address width
  localparam int          EMBI_AREAS   = 8;    // Number of address areas
  // Transfer sizes on the request port
  localparam logic [1:0]  SZ_BYTE      = 2'h0;
  localparam logic [1:0]  SZ_WORD      = 2'h1;
  localparam logic [1:0]  SZ_LONG      = 2'h2;
  // Power-on values of the bus controller registers
  localparam logic [7:0]  RST_BUS_WIDTH   = 8'h00; // 16-bit in every area
  localparam logic [7:0]  RST_ACC_STATES  = 8'hff; // 3-state in every area
  localparam logic [7:0]  RST_WAIT_COUNT  = 8'hff; // 3 wait states per area
  localparam logic        RST_WAIT_PIN_EN = 1'h0;
  localparam logic        RST_BURST_SEL   = 1'h0;
  localparam logic        RST_BURST_LEN   = 1'h0;
  localparam logic        RST_BURST_LIM   = 1'h0;
  // Burst run limits in words
  localparam logic [3:0]  BURST_LIM_SHORT = 4'h4;
  localparam logic [3:0]  BURST_LIM_LONG  = 4'h8;
  // Bus states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_T1    = 6'b000010,
    ST_T2    = 6'b000100,
    ST_TW    = 6'b001000,
    ST_T3    = 6'b010000,
    ST_BURST = 6'b100000
  } embi_state_t;
endpackage

// >>> verilog/embi_lane_steer.sv
// Byte-lane steering for one bus access: lane enables, write data, read data
`timescale 1ns/1ps
`default_nettype none
module embi_lane_steer (
  input  wire logic        bus8,
  input  wire logic        word,
  input  wire logic        odd,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] din,
  output logic             up_used,
  output logic             lo_used,
  output logic [15:0]      dout,
  output logic [15:0]      rval
);
  // Upper lane for 8-bit space, words and even bytes
  assign up_used = bus8 | word | ~odd;
  assign lo_used = ~bus8 & (word | odd);
  // Byte copied on both lanes; enables pick the live one
  assign dout    = word ? wdata : {wdata[7:0], wdata[7:0]};
  // Unused lane is read but its value is dropped
  assign rval    = word ? din : (up_used ? {8'h00, din[15:8]} : {8'h00, din[7:0]});
endmodule // embi_lane_steer
`default_nettype wire

// >>> verilog/embi_bus_ctrl.sv
// External memory bus interface: basic and burst ROM access sequencer
`timescale 1ns/1ps
`default_nettype none
module embi_bus_ctrl
  import embi_pkg::*;
#(
  parameter int ADDR_W = EMBI_ADDR_W
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              manual_rst_n,
  input  wire logic              clk_en,
  // Configuration load
  input  wire logic              cfg_load,
  input  wire logic [7:0]        cfg_bus_width,
  input  wire logic [7:0]        cfg_access_states,
  input  wire logic [7:0]        cfg_wait_count_upper,
  input  wire logic [7:0]        cfg_wait_count_lower,
  input  wire logic              cfg_wait_pin_enable,
  input  wire logic              cfg_burst_rom_select,
  input  wire logic              cfg_burst_cycle_length,
  input  wire logic              cfg_burst_word_limit,
  // Configuration readback
  output logic [7:0]             bus_width_control_reg,
  output logic [7:0]             access_state_control_reg,
  output logic [7:0]             wait_count_upper_reg,
  output logic [7:0]             wait_count_lower_reg,
  output logic                   wait_pin_enable,
  output logic                   burst_rom_select,
  output logic                   burst_cycle_length,
  output logic                   burst_word_limit,
  // Internal master request
  input  wire logic              req_valid,
  input  wire logic [2:0]        req_area,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [1:0]        req_size,
  input  wire logic              req_write,
  input  wire logic              req_ifetch,
  input  wire logic [31:0]       req_wdata,
  output logic                   req_ready,
  output logic                   resp_valid,
  output logic [31:0]            resp_rdata,
  // External pins
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   rd_n,
  output logic                   upper_write_strobe_n,
  output logic                   lower_write_strobe_n,
  output logic [15:0]            data_out,
  output logic                   data_oe_upper,
  output logic                   data_oe_lower,
  input  wire logic [15:0]       data_in,
  input  wire logic              wait_n
);

  // Parameter range the address arithmetic can serve
  if (ADDR_W < 2 || ADDR_W > 32) begin : g_bad_addr_w
    $error("embi_bus_ctrl: ADDR_W must lie in 2..32");
  end

  typedef struct packed {
    embi_state_t       state;
    // Configuration registers
    logic [7:0]        bw;
    logic [7:0]        ast;
    logic [15:0]       wc;
    logic              wpe;
    logic              brs;
    logic              bcl;
    logic              bwl;
    // Current access descriptor
    logic              bus8;
    logic              three;
    logic              bmode;
    logic [1:0]        pw;
    logic [1:0]        wcnt;
    logic              bst;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        size;
    logic              wr;
    logic [31:0]       wdata;
    logic [31:0]       rdata;
    logic [2:0]        nbeats;
    logic [2:0]        beat;
    // Open burst run
    logic              bopen;
    logic [ADDR_W-1:0] bnext;
    logic [3:0]        bwords;
    // Registered outputs
    logic              ready;
    logic              rvalid;
    logic [ADDR_W-1:0] pa;
    logic              prd_n;
    logic              phw_n;
    logic              plw_n;
    logic [15:0]       pd;
    logic              poe_up;
    logic              poe_lo;
  } embi_regs_t;

  embi_regs_t s;
  embi_regs_t next_s;
  logic       rst_meta_n;
  logic       rst_sync_n;

  // Number of bus accesses for one transfer
  function automatic logic [2:0] beat_count(input logic [1:0] sz, input logic b8);
    if (b8) begin
      beat_count = (sz == SZ_BYTE) ? 3'h1 : (sz == SZ_WORD) ? 3'h2 : 3'h4;
    end else begin
      beat_count = (sz == SZ_LONG) ? 3'h2 : 3'h1;
    end
  endfunction

  // Slice of write data for beat k, most significant first
  function automatic logic [15:0] beat_data(input logic [31:0] d, input logic wd,
                                            input logic [2:0] nb, input logic [2:0] k);
    logic [2:0] idx;
    idx       = nb - 3'h1 - k;
    beat_data = wd ? d[{idx[0], 4'h0} +: 16] : {8'h00, d[{idx[1:0], 3'h0} +: 8]};
  endfunction

  // Values taken at power-on and, except configuration, at manual reset
  function automatic embi_regs_t reset_regs();
    embi_regs_t r;
    r        = '0;
    r.state  = ST_IDLE;
    r.bw     = RST_BUS_WIDTH;
    r.ast    = RST_ACC_STATES;
    r.wc     = {RST_WAIT_COUNT, RST_WAIT_COUNT};
    r.wpe    = RST_WAIT_PIN_EN;
    r.brs    = RST_BURST_SEL;
    r.bcl    = RST_BURST_LEN;
    r.bwl    = RST_BURST_LIM;
    r.ready  = 1'b1;
    r.prd_n  = 1'b1;
    r.phw_n  = 1'b1;
    r.plw_n  = 1'b1;
    reset_regs = r;
  endfunction

  // Word access unless the beat is a single byte
  logic        cur_word;
  logic        up_used;
  logic        lo_used;
  logic [15:0] lane_dout;
  logic [15:0] lane_rval;
  assign cur_word = ~s.bus8 & (s.size != SZ_BYTE);

  embi_lane_steer u_lane (
    .bus8    (s.bus8),
    .word    (cur_word),
    .odd     (s.addr[0]),
    .wdata   (beat_data(s.wdata, cur_word, s.nbeats, s.beat)),
    .din     (data_in),
    .up_used (up_used),
    .lo_used (lo_used),
    .dout    (lane_dout),
    .rval    (lane_rval)
  );

  // Next-state logic for the whole block
  always_comb begin
    logic [3:0]        lim;
    logic              take_burst;
    logic              end_beat;
    logic              pin_wait;
    logic [ADDR_W-1:0] step_addr;
    next_s        = s;
    next_s.rvalid = 1'b0;
    end_beat      = 1'b0;
    lim           = s.bwl ? BURST_LIM_LONG : BURST_LIM_SHORT;
    pin_wait      = s.wpe & ~wait_n;
    step_addr     = s.addr + (cur_word ? ADDR_W'(2) : ADDR_W'(1));
    take_burst    = s.brs && req_area == 3'h0 && req_ifetch && !req_write;

    // Configuration writes, accepted in any state
    if (cfg_load) begin
      next_s.bw  = cfg_bus_width;
      next_s.ast = cfg_access_states;
      next_s.wc  = {cfg_wait_count_upper, cfg_wait_count_lower};
      next_s.wpe = cfg_wait_pin_enable;
      next_s.brs = cfg_burst_rom_select;
      next_s.bcl = cfg_burst_cycle_length;
      next_s.bwl = cfg_burst_word_limit;
    end

    unique case (s.state)
      ST_IDLE: begin
        if (req_valid && s.ready) begin
          next_s.ready  = 1'b0;
          next_s.bmode  = take_burst;
          next_s.bus8   = take_burst ? 1'b0 : s.bw[req_area];
          next_s.three  = s.ast[req_area];
          next_s.pw     = s.wc[{req_area, 1'b0} +: 2];
          next_s.wcnt   = s.wc[{req_area, 1'b0} +: 2];
          next_s.addr   = req_addr;
          next_s.size   = req_size;
          next_s.wr     = req_write;
          next_s.wdata  = req_wdata;
          next_s.rdata  = '0;
          next_s.beat   = 3'h0;
          next_s.bst    = 1'b0;
          next_s.nbeats = beat_count(req_size, take_burst ? 1'b0 : s.bw[req_area]);
          // Continue an open run at the next sequential word
          if (take_burst && s.bopen && req_addr == s.bnext && s.bwords < lim) begin
            next_s.state = ST_BURST;
          end else begin
            next_s.state  = ST_T1;
            next_s.bopen  = 1'b0;
            next_s.bwords = 4'h0;
          end
        end
      end
      ST_T1: begin
        next_s.state = ST_T2;
      end
      ST_T2, ST_TW: begin
        // Programmed waits run out before the pin is looked at
        if (s.three && s.wcnt != 2'h0) begin
          next_s.state = ST_TW;
          next_s.wcnt  = s.wcnt - 2'h1;
        end else if (s.three && pin_wait) begin
          next_s.state = ST_TW;
        end else if (s.three) begin
          next_s.state = ST_T3;
        end else begin
          end_beat = 1'b1;
        end
      end
      ST_T3: begin
        end_beat = 1'b1;
      end
      ST_BURST: begin
        // Second state only when the long burst cycle is chosen
        if (s.bcl && !s.bst) begin
          next_s.bst = 1'b1;
        end else begin
          end_beat = 1'b1;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase

    // Close one access: collect read data, then next beat or finish
    if (end_beat) begin
      if (!s.wr) begin
        next_s.rdata = cur_word ? {s.rdata[15:0], lane_rval} : {s.rdata[23:0], lane_rval[7:0]};
      end
      if (s.bmode) begin
        next_s.bwords = (s.state == ST_BURST) ? s.bwords + 4'h1 : 4'h1;
      end
      next_s.bst  = 1'b0;
      next_s.wcnt = s.pw;
      next_s.addr = step_addr;
      if (s.beat + 3'h1 < s.nbeats) begin
        next_s.beat  = s.beat + 3'h1;
        next_s.state = (s.bmode && next_s.bwords < lim) ? ST_BURST : ST_T1;
      end else begin
        next_s.state  = ST_IDLE;
        next_s.ready  = 1'b1;
        next_s.rvalid = 1'b1;
        next_s.bopen  = s.bmode;
        next_s.bnext  = step_addr;
      end
    end

    // Pins for the coming state; strobes start one state after the address in basic cycles, with it in ST_BURST
    next_s.pa     = next_s.addr;
    next_s.prd_n  = 1'b1;
    next_s.phw_n  = 1'b1;
    next_s.plw_n  = 1'b1;
    next_s.poe_up = 1'b0;
    next_s.poe_lo = 1'b0;
    next_s.pd     = lane_dout;
    if (next_s.state inside {ST_T2, ST_TW, ST_T3, ST_BURST}) begin
      if (!s.wr) begin
        next_s.prd_n = 1'b0;
      end else begin
        next_s.poe_up = up_used;
        next_s.poe_lo = lo_used;
        // Strobes lift in the third state so data holds past them
        if (next_s.state != ST_T3) begin
          next_s.phw_n = ~up_used;
          next_s.plw_n = ~lo_used;
        end
      end
    end

    // Manual reset aborts the cycle but keeps configuration
    if (!manual_rst_n) begin
      next_s     = reset_regs();
      next_s.bw  = s.bw;
      next_s.ast = s.ast;
      next_s.wc  = s.wc;
      next_s.wpe = s.wpe;
      next_s.brs = s.brs;
      next_s.bcl = s.bcl;
      next_s.bwl = s.bwl;
    end
  end

  // Reset release synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s <= reset_regs();
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign bus_width_control_reg    = s.bw;
  assign access_state_control_reg = s.ast;
  assign wait_count_upper_reg     = s.wc[15:8];
  assign wait_count_lower_reg     = s.wc[7:0];
  assign wait_pin_enable          = s.wpe;
  assign burst_rom_select         = s.brs;
  assign burst_cycle_length       = s.bcl;
  assign burst_word_limit         = s.bwl;
  assign req_ready                = s.ready;
  assign resp_valid               = s.rvalid;
  assign resp_rdata               = s.rdata;
  assign addr_out                 = s.pa;
  assign rd_n                     = s.prd_n;
  assign upper_write_strobe_n     = s.phw_n;
  assign lower_write_strobe_n     = s.plw_n;
  assign data_out                 = s.pd;
  assign data_oe_upper            = s.poe_up;
  assign data_oe_lower            = s.poe_lo;

endmodule // embi_bus_ctrl
`default_nettype wire

// >>> bench/embi_bus_props.sv
// Checker: port-level properties of the external memory bus interface
`timescale 1ns/1ps
`default_nettype none
module embi_bus_props
  import embi_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       manual_rst_n,
  input wire logic       cfg_load,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [2:0] req_area,
  input wire logic [1:0] req_size,
  input wire logic       req_ifetch,
  input wire logic       resp_valid,
  input wire logic       rd_n,
  input wire logic       upper_write_strobe_n,
  input wire logic       lower_write_strobe_n,
  input wire logic       data_oe_upper,
  input wire logic       data_oe_lower,
  input wire logic [7:0] bus_width_control_reg,
  input wire logic [7:0] access_state_control_reg,
  input wire logic [7:0] wait_count_lower_reg,
  input wire logic       wait_pin_enable,
  input wire logic       burst_rom_select
);
  logic       take;
  logic [2:0] cur_area;
  logic [3:0] lat;
  logic [3:0] exp_lat;
  assign take = req_valid && req_ready;
  // Cycles since take; expected length kept only for plain byte accesses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_area <= 3'h0;
      lat      <= 4'hf;
      exp_lat  <= 4'h0;
    end else if (take) begin
      cur_area <= req_area;
      lat      <= 4'h1;
      exp_lat  <= (req_size != SZ_BYTE || req_area[2] || wait_pin_enable
                  || (burst_rom_select && req_ifetch)) ? 4'h0
                  : !access_state_control_reg[req_area] ? 4'h3
                  : 4'h4 + {2'h0, wait_count_lower_reg[{req_area[1:0], 1'b0} +: 2]};
    end else if (lat != 4'hf) begin
      lat <= lat + 4'h1;
    end
  end
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_oe_rd; (data_oe_upper || data_oe_lower) |-> rd_n; endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("lane driven during read");
  property p_lane_hiz; !upper_write_strobe_n && lower_write_strobe_n |-> !data_oe_lower; endproperty
  a_lane_hiz: assert property (p_lane_hiz) else $error("unused lane driven");
  property p_strobe_oe; !upper_write_strobe_n |-> data_oe_upper && rd_n; endproperty
  a_strobe_oe: assert property (p_strobe_oe) else $error("strobe without data");
  property p_lws8; !lower_write_strobe_n |-> !bus_width_control_reg[cur_area]; endproperty
  a_lws8: assert property (p_lws8) else $error("lower strobe in 8-bit space");
  property p_lo8; data_oe_lower |-> !bus_width_control_reg[cur_area]; endproperty
  a_lo8: assert property (p_lo8) else $error("lower lane used in 8-bit space");
  property p_two_state;
    take && req_size == SZ_BYTE && !access_state_control_reg[req_area]
      && !(burst_rom_select && req_ifetch) |-> ##3 resp_valid;
  endproperty
  a_two_state: assert property (p_two_state) else $error("2-state length wrong");
  property p_lat; resp_valid && exp_lat != 4'h0 |-> lat == exp_lat; endproperty
  a_lat: assert property (p_lat) else $error("programmed wait count wrong");
  property p_por;
    $rose(rst_n) |-> access_state_control_reg == 8'hff && wait_count_lower_reg == 8'hff
      && !wait_pin_enable;
  endproperty
  a_por: assert property (p_por) else $error("power-on settings wrong");
  property p_keep;
    !manual_rst_n && !cfg_load |=> $stable(access_state_control_reg)
      && $stable(wait_count_lower_reg) && $stable(bus_width_control_reg);
  endproperty
  a_keep: assert property (p_keep) else $error("manual reset changed settings");
  // Main scenarios reached
  c_burst: cover property (take && req_ifetch && burst_rom_select);
  c_word_wr: cover property (!upper_write_strobe_n && !lower_write_strobe_n);
  c_long_wait: cover property (resp_valid && lat > 4'h6);
endmodule // embi_bus_props
bind embi_bus_ctrl embi_bus_props props_u (.*);
`default_nettype wire

// >>> bench/embi_mem_model.sv
// Behavioural external memory: byte array on both lanes, wait pin driver
`timescale 1ns/1ps
`default_nettype none
module embi_mem_model (
  input  wire logic        sys_clk,
  input  wire logic [23:0] addr_out,
  input  wire logic        rd_n,
  input  wire logic        upper_write_strobe_n,
  input  wire logic        lower_write_strobe_n,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe_upper,
  input  wire logic        data_oe_lower,
  input  wire logic [3:0]  wlen,
  input  wire logic        narrow,
  output logic [15:0]      data_in,
  output logic             wait_n
);
  logic [7:0]  mem [64];
  logic [15:0] last = 16'h0;
  logic [23:0] last_a = 24'h0;
  logic [3:0]  cnt = 4'h0;
  logic        act;
  logic [5:0]  a;
  logic [5:0]  ua;
  // Byte i holds i, so expected data follows from the address alone
  initial for (int i = 0; i < 64; i++) mem[i] = 8'(i);
  assign a = addr_out[5:0];
  // Byte-wide part sits on the upper lane; a wide part pairs even and odd
  assign ua = narrow ? a : {a[5:1], 1'b0};
  assign act = !(rd_n && upper_write_strobe_n && lower_write_strobe_n);
  // Valid only under the read strobe; otherwise a toggling pattern
  assign data_in = !rd_n ? {mem[ua], mem[a | 6'h01]} : ~last;
  // Low for the first wlen cycles of a basic access; on burst beats the count restarts a cycle after the address moves
  assign wait_n = !(act && cnt < wlen);
  // Count restarts on a new address; writes land per lane
  always @(posedge sys_clk) begin
    last <= data_in;
    last_a <= addr_out;
    cnt <= (act && addr_out == last_a && cnt != 4'hf) ? cnt + 4'h1 : 4'h0;
    if (!upper_write_strobe_n && data_oe_upper) mem[ua] <= data_out[15:8];
    if (!lower_write_strobe_n && data_oe_lower) mem[a | 6'h01] <= data_out[7:0];
  end
endmodule // embi_mem_model
`default_nettype wire

// >>> bench/tb.sv
// Testbench: directed transfers against a behavioural memory
`timescale 1ns/1ps
`default_nettype none
module tb;
  import embi_pkg::*;
  logic        sys_clk = 1'b0, rst_n = 1'b0, manual_rst_n = 1'b1, clk_en = 1'b1;
  logic        cfg_load = 1'b0, cfg_wait_pin_enable, cfg_burst_rom_select;
  logic        cfg_burst_cycle_length, cfg_burst_word_limit;
  logic [7:0]  cfg_bus_width, cfg_access_states, cfg_wait_count_lower;
  logic [7:0]  cfg_wait_count_upper = 8'h00, bus_width_control_reg;
  logic [7:0]  access_state_control_reg, wait_count_upper_reg, wait_count_lower_reg;
  logic        wait_pin_enable, burst_rom_select, burst_cycle_length, burst_word_limit;
  logic        req_valid = 1'b0, req_write, req_ifetch, req_ready, resp_valid;
  logic [2:0]  req_area;
  logic [23:0] req_addr, addr_out;
  logic [1:0]  req_size;
  logic [31:0] req_wdata, resp_rdata, rd;
  logic        rd_n, upper_write_strobe_n, lower_write_strobe_n, wait_n;
  logic [15:0] data_out, data_in;
  logic        data_oe_upper, data_oe_lower;
  logic [3:0]  wlen = 4'h0;
  logic        narrow = 1'b0;
  int          error_cnt = 0, checked = 0, acc = 0, lat = 0, cyc = 0, ls[4];
  embi_bus_ctrl  dut_u (.*);
  embi_mem_model mem_u (.*);
  // Clock, hang limit and count of strobe assertions
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  always @(negedge (rd_n & upper_write_strobe_n & lower_write_strobe_n)) acc++;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // Settings land at the edge with the load strobe high
  task automatic cfg(input logic [7:0] bw, ast, wcl, input logic [3:0] f);
    {cfg_bus_width, cfg_access_states, cfg_wait_count_lower} = {bw, ast, wcl};
    {cfg_wait_pin_enable, cfg_burst_rom_select, cfg_burst_cycle_length,
     cfg_burst_word_limit} = f;
    cfg_load = 1'b1;
    @(posedge sys_clk) #1;
    cfg_load = 1'b0;
  endtask
  // Only called while idle, so the next edge takes the request
  task automatic xfer(input logic [2:0] ar, input logic [23:0] ad, input logic [1:0] sz,
                      input logic [1:0] wf, input logic [31:0] wd);
    {req_area, req_addr, req_size, req_write, req_ifetch, req_wdata} = {ar, ad, sz, wf, wd};
    acc = 0;
    req_valid = 1'b1;
    @(posedge sys_clk) #1;
    req_valid = 1'b0;
    // Latency counts the take edge as the first one
    lat = 1;
    repeat (100) begin
      @(posedge sys_clk) #1;
      lat++;
      if (resp_valid === 1'b1) break;
    end
    if (resp_valid !== 1'b1) begin
      $display("[ERR] resp_valid expected 1 seen %b", resp_valid);
      error_cnt++;
    end
    rd = resp_rdata;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {cfg_bus_width, cfg_access_states, cfg_wait_count_lower} = 24'h0;
    {cfg_wait_pin_enable, cfg_burst_rom_select} = 2'h0;
    {cfg_burst_cycle_length, cfg_burst_word_limit} = 2'h0;
    {req_write, req_ifetch, req_area, req_addr, req_size, req_wdata} = '0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge sys_clk) #1;
    chk("states", 32'hff, 32'(access_state_control_reg));
    chk("waits", 32'hff, 32'(wait_count_lower_reg));
    chk("waits_up", 32'hff, 32'(wait_count_upper_reg));
    chk("pin_en", 32'h0, 32'(wait_pin_enable));
    xfer(3'h0, 24'h1, SZ_BYTE, 2'h0, 32'h0);
    chk("por_lat", 32'h7, 32'(lat));
    chk("por_rd", 32'h01, rd);
    $display("test power_on done");
    // 16-bit 2-state with the wait pin pulled low: no extension
    cfg(8'h00, 8'h00, 8'h00, 4'h8);
    wlen = 4'h3;
    xfer(3'h1, 24'h11, SZ_BYTE, 2'h0, 32'h0);
    chk("odd_rd", 32'h11, rd);
    chk("lat2", 32'h3, 32'(lat));
    xfer(3'h1, 24'h20, SZ_LONG, 2'h0, 32'h0);
    chk("long_rd", 32'h20212223, rd);
    chk("long_acc", 32'h2, 32'(acc));
    xfer(3'h1, 24'h30, SZ_WORD, 2'h2, 32'hbeef);
    xfer(3'h1, 24'h31, SZ_BYTE, 2'h2, 32'h77);
    xfer(3'h1, 24'h32, SZ_BYTE, 2'h2, 32'h5c);
    xfer(3'h1, 24'h30, SZ_LONG, 2'h0, 32'h0);
    chk("lane_wr", 32'hbe775c33, rd);
    $display("test wide_two_state done");
    // 8-bit 3-state area 2: two programmed waits with pin disabled, then 0 to 3 programmed waits plus 2 from the pin with pin enabled
    narrow = 1'b1;
    cfg(8'h04, 8'h04, 8'h20, 4'h0);
    xfer(3'h2, 24'h08, SZ_LONG, 2'h0, 32'h0);
    chk("b8_rd", 32'h08090a0b, rd);
    chk("b8_acc", 32'h4, 32'(acc));
    xfer(3'h2, 24'h05, SZ_BYTE, 2'h0, 32'h0);
    chk("pin_off", 32'h6, 32'(lat));
    xfer(3'h2, 24'h38, SZ_LONG, 2'h2, 32'hcafef00d);
    xfer(3'h2, 24'h38, SZ_LONG, 2'h0, 32'h0);
    chk("b8_wr", 32'hcafef00d, rd);
    for (int w = 0; w < 4; w++) begin
      cfg(8'h04, 8'h04, 8'(w << 4), 4'h8);
      wlen = 4'(w + 2);
      xfer(3'h2, 24'h05, SZ_BYTE, 2'h0, 32'h0);
      chk("wait_len", 32'(6 + w), 32'(lat));
    end
    manual_rst_n = 1'b0;
    @(posedge sys_clk) #1;
    manual_rst_n = 1'b1;
    @(posedge sys_clk) #1;
    chk("kept_cfg", {8'h04, 8'h04, 8'h30, 4'h8, 4'h0}, {bus_width_control_reg, access_state_control_reg, wait_count_lower_reg, wait_pin_enable, burst_rom_select, burst_cycle_length, burst_word_limit, 4'h0});
    xfer(3'h2, 24'h05, SZ_BYTE, 2'h0, 32'h0);
    chk("kept_lat", 32'h9, 32'(lat));
    $display("test narrow_three_state done");
    // Burst area 0 declared 8-bit, one programmed-free full access
    narrow = 1'b0;
    cfg(8'h01, 8'h01, 8'h00, 4'h4);
    wlen = 4'h2;
    xfer(3'h0, 24'h00, SZ_LONG, 2'h1, 32'h0);
    ls[0] = lat;
    chk("burst_rd", 32'h00010203, rd);
    xfer(3'h0, 24'h10, SZ_LONG, 2'h0, 32'h0);
    chk("data_acc", 32'h4, 32'(acc));
    cfg(8'h01, 8'h01, 8'h00, 4'hc);
    xfer(3'h0, 24'h40, SZ_LONG, 2'h1, 32'h0);
    chk("burst_wait", 32'(ls[0] + 2), 32'(lat));
    cfg(8'h01, 8'h01, 8'h00, 4'h6);
    xfer(3'h0, 24'h50, SZ_LONG, 2'h1, 32'h0);
    chk("beat_len", 32'(ls[0] + 1), 32'(lat));
    for (int m = 0; m < 2; m++) begin
      cfg(8'h01, 8'h01, 8'h00, 4'(4 + m));
      for (int k = 0; k < 4; k++) begin
        xfer(3'h0, 24'(256 * (m + 1) + 4 * k), SZ_LONG, 2'h1, 32'h0);
        ls[k] = lat;
      end
      chk("run_limit", 32'h1, 32'(m ? ls[2] == ls[1] : ls[2] > ls[1]));
    end
    $display("test burst done");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
